//--- pkg/svi_regs.svh
// Register offsets, field positions, reset values and vector constants for the interrupt unit
`ifndef SVI_REGS_SVH
`define SVI_REGS_SVH

// Byte addresses of the registers on the Avalon-MM bus
`define SVI_ADDR_T0DATA    8'hd1
`define SVI_ADDR_T0CTL     8'hd2
`define SVI_ADDR_SYSMODE   8'hdf
`define SVI_ADDR_P0CFG     8'he7
`define SVI_ADDR_PINPND    8'he8
`define SVI_ADDR_PWMDB     8'hf0
`define SVI_ADDR_PWM_DUTY_REG   8'hf2
`define SVI_ADDR_PWMCTL    8'hf3

// Field positions
`define SVI_SYM_GIE        3
`define SVI_PAGE_LSB       0
`define SVI_PAGE_MSB       2
`define SVI_CTL_PEND       0
`define SVI_CTL_EN         1
`define SVI_CTL_CLR        3
`define SVI_PIN0_PEND      0
`define SVI_PIN0_EN        1
`define SVI_PIN1_PEND      2
`define SVI_PIN1_EN        3

// Writable masks and reset values
`define SVI_SYM_MASK       8'h0f
`define SVI_T0_MASK        8'hcb
`define SVI_PWM_MASK       8'hdf
`define SVI_PIN_MASK       8'h0f
`define SVI_RST_BYTE       8'h00

// Vector locations of the handler address
`define SVI_VEC_HI_ADDR    16'h0000
`define SVI_VEC_LO_ADDR    16'h0001

// Number of request sources and their index
`define SVI_NSRC           4
`define SVI_SRC_PWM        0
`define SVI_SRC_T0         1
`define SVI_SRC_PIN0       2
`define SVI_SRC_PIN1       3

`endif

//--- pkg/svi_pkg.sv
// Types shared by the interrupt unit and its bench
package svi_pkg;
	// Sequencer steps of the interrupt machine cycle
	typedef enum logic [3:0] {
		SVI_IDLE,
		SVI_PUSH_PCL,
		SVI_PUSH_PCH,
		SVI_PUSH_FLG,
		SVI_FETCH_HI,
		SVI_FETCH_LO,
		SVI_BRANCH,
		SVI_POP_FLG,
		SVI_POP_PCH,
		SVI_POP_PCL
	} svi_state_t;

	// Memory request toward the core's stack and program memory
	typedef struct packed {
		logic        push;   // Write one byte to the stack
		logic        pop;    // Read one byte from the stack
		logic        fetch;  // Read one byte from program memory
		logic [15:0] addr;   // Program memory address for fetch
		logic [7:0]  wdata;  // Byte pushed onto the stack
	} svi_mem_req_t;

	// Branch target handed back to the core
	typedef struct packed {
		logic        load;   // One-cycle pulse: load pc and flags
		logic [15:0] pc;     // New program counter
		logic [7:0]  flags;  // New flags (valid on return only)
		logic        is_ret; // Load came from a return, flags valid
	} svi_branch_t;
endpackage

//--- core/svi_unit.sv
// Single-vector interrupt unit: registers, request logic and service sequencer
`timescale 1ns/1ps
`default_nettype none
`include "svi_regs.svh"

// What this block does
// - System mode bit 3 gates all requests
// - One shared vector at program address zero
// - Take request at instruction end when enabled
// - Interrupt cycle clears the global gate first
// - Push pc low, pc high, then flags
// - Fetch handler high then low, then branch
// - Return restores pc, flags and sets gate
// - No hardware priority; software polls sources
// - Pending stays set until software clears it
// - Four sources: pwm, timer, two pins
// - Pwm control bit 1 enables overflow request
// - Pwm bit 0 pending; write 0 clears
// - Timer control bit 1 enables match request
// - Timer bit 0 pending; write 0 clears
// - Bit 3 clears counter, not self-clearing
// - Registers at their fixed byte addresses
// - Low three mode bits select page
// - Pin register: enables and pending per line
module svi_unit
	import svi_pkg::*;
(
	input  wire logic         i_clock,         // System clock, 40 MHz
	input  wire logic         i_rst,           // Synchronous reset, active high
	input  wire logic [7:0]   i_address,       // Avalon byte address
	input  wire logic         i_read,          // Avalon read
	input  wire logic         i_write,         // Avalon write
	input  wire logic [7:0]   i_writedata,     // Avalon write data
	output logic      [7:0]   o_readdata,      // Avalon read data
	output logic              o_waitrequest,   // Avalon wait request
	input  wire logic         i_pwm_ovf,       // Pwm 8-bit overflow pulse
	input  wire logic         i_t0_match,      // Timer 0 match pulse
	input  wire logic         i_pin0,          // External line zero pin
	input  wire logic         i_pin1,          // External line one pin
	input  wire logic         i_instr_end,     // Core is at an instruction boundary
	input  wire logic         i_irq_on,        // Core executes global enable instr
	input  wire logic         i_irq_off,       // Core executes global disable instr
	input  wire logic         i_return_from_interrupt,          // Core executes return from interrupt
	input  wire logic [15:0]  i_pc,            // Core program counter
	input  wire logic [7:0]   i_flags,         // Core flags register
	input  wire logic         i_mem_ready,     // Stack or program memory step done
	input  wire logic [7:0]   i_mem_rdata,     // Byte read by pop or fetch
	output logic              o_irq_req,       // Gated request level to the core
	output logic              o_busy,          // Sequencer owns the core
	output svi_mem_req_t      o_mem,           // Stack and program memory request
	output svi_branch_t       o_branch,        // Branch target to the core
	output logic              o_pwm_clr,       // Pwm counter clear level
	output logic              o_t0_clr,        // Timer 0 counter clear level
	output logic      [7:0]   o_t0_ctl,        // Timer 0 control for the timer
	output logic      [7:0]   o_pwm_ctl,       // Pwm control for the pwm
	output logic      [7:0]   o_t0_data,       // Timer 0 match value
	output logic      [7:0]   o_pwm_data,      // Pwm duty value
	output logic      [7:0]   o_pwm_data_b,    // Pwm second duty value
	output logic      [7:0]   o_p0_cfg,        // Port zero configuration
	output logic      [2:0]   o_page           // Selected register page
);

	// Register bank
	logic [7:0]        system_mode_reg_r;        // Gate and page
	logic [7:0]        timer0_control_reg_r;     // Timer control with pending
	logic [7:0]        pwm_control_reg_r;        // Pwm control with pending
	logic [7:0]        pin_irq_pending_reg_r;    // Pin enables and pendings
	logic [7:0]        timer0_match_value_reg_r; // Timer match value
	logic [7:0]        pwm_duty_reg_r;           // Pwm duty
	logic [7:0]        pwm_duty_reg_b_r;         // Pwm second duty
	logic [7:0]        port_zero_config_low_reg_r; // Pin configuration
	logic              rd_done_r;                // Read answer cycle
	logic [7:0]        rdata_r;                  // Registered read data
	svi_state_t        state_r;                  // Sequencer step
	svi_state_t        state_nxt;                // Next sequencer step
	logic [7:0]        vec_hi_r;                 // Handler high byte
	logic [7:0]        pop_flg_r;                // Flags popped on return
	logic [7:0]        pop_pch_r;                // Pc high popped on return
	logic [1:0]        pin0_sync_r;              // Line zero synchroniser
	logic [1:0]        pin1_sync_r;              // Line one synchroniser
	logic              pin0_last_r;              // Line zero previous level
	logic              pin1_last_r;              // Line one previous level
	logic [3:0]        src_pend;                 // Pending per source
	logic [3:0]        src_en;                   // Enable per source
	logic              wr;                       // Accepted register write
	logic              pin0_fall;                // Line zero falling edge
	logic              pin1_fall;                // Line one falling edge
	logic              take;                     // Acknowledge this cycle

	// Merge a written byte with a pending bit that only accepts a clear
	function automatic logic clr_only(input logic cur, input logic wbit, input logic ev);
		clr_only = ev | (cur & wbit);
	endfunction

	// Address match for an accepted write
	function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] r);
		wr_hit = w & (a == r);
	endfunction

	// Writes finish in the request cycle; reads answer one cycle later
	assign o_waitrequest = i_read & ~rd_done_r;
	assign wr            = i_write & ~i_read;

	// Pins pass two flip-flops before the edge detector looks at them
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			pin0_sync_r <= 2'h3;
			pin1_sync_r <= 2'h3;
			pin0_last_r <= 1'b1;
			pin1_last_r <= 1'b1;
		end else begin
			pin0_sync_r <= {pin0_sync_r[0], i_pin0};
			pin1_sync_r <= {pin1_sync_r[0], i_pin1};
			pin0_last_r <= pin0_sync_r[1];
			pin1_last_r <= pin1_sync_r[1];
		end
	end

	// Falling edges count only while the line's enable is set
	assign pin0_fall = pin0_last_r & ~pin0_sync_r[1] & pin_irq_pending_reg_r[`SVI_PIN0_EN];
	assign pin1_fall = pin1_last_r & ~pin1_sync_r[1] & pin_irq_pending_reg_r[`SVI_PIN1_EN];

	// Read answer: one wait cycle, then data stands with waitrequest low
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			rd_done_r <= 1'b0;
			rdata_r   <= `SVI_RST_BYTE;
		end else begin
			rd_done_r <= i_read & ~rd_done_r;
			if (i_read & ~rd_done_r) begin
				case (i_address)
					`SVI_ADDR_T0DATA:  rdata_r <= timer0_match_value_reg_r;
					`SVI_ADDR_T0CTL:   rdata_r <= timer0_control_reg_r;
					`SVI_ADDR_SYSMODE: rdata_r <= system_mode_reg_r;
					`SVI_ADDR_P0CFG:   rdata_r <= port_zero_config_low_reg_r;
					`SVI_ADDR_PINPND:  rdata_r <= pin_irq_pending_reg_r;
					`SVI_ADDR_PWMDB:   rdata_r <= pwm_duty_reg_b_r;
					`SVI_ADDR_PWM_DUTY_REG: rdata_r <= pwm_duty_reg_r;
					`SVI_ADDR_PWMCTL:  rdata_r <= pwm_control_reg_r;
					default:           rdata_r <= `SVI_RST_BYTE; // Unmapped reads zero
				endcase
			end
		end
	end
	assign o_readdata = rdata_r;

	// System mode: gate bit driven by writes, instructions and the sequencer
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			system_mode_reg_r <= `SVI_RST_BYTE; // Gate off until boot code enables it
		end else begin
			if (wr_hit(wr, i_address, `SVI_ADDR_SYSMODE)) begin
				system_mode_reg_r <= i_writedata & `SVI_SYM_MASK;
			end
			if (i_irq_on | i_return_from_interrupt) begin
				system_mode_reg_r[`SVI_SYM_GIE] <= 1'b1;
			end
			if (i_irq_off) begin
				system_mode_reg_r[`SVI_SYM_GIE] <= 1'b0;
			end
			// Acknowledge wins over everything so no second request sneaks in
			if (take) begin
				system_mode_reg_r[`SVI_SYM_GIE] <= 1'b0;
			end
		end
	end
	// Pages 1 to 7 have no registers here; the page is only passed on
	assign o_page = system_mode_reg_r[`SVI_PAGE_MSB:`SVI_PAGE_LSB];

	// Timer 0 control: pending set by match, cleared only by writing 0
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			timer0_control_reg_r <= `SVI_RST_BYTE;
		end else begin
			if (wr_hit(wr, i_address, `SVI_ADDR_T0CTL)) begin
				// Clear bit is stored as written and stays until rewritten
				timer0_control_reg_r <= i_writedata & `SVI_T0_MASK;
			end
			// A match in the clearing cycle still sets the flag
			timer0_control_reg_r[`SVI_CTL_PEND] <= clr_only(timer0_control_reg_r[`SVI_CTL_PEND],
				~wr_hit(wr, i_address, `SVI_ADDR_T0CTL) | i_writedata[`SVI_CTL_PEND],
				i_t0_match);
		end
	end

	// Pwm control: same pending behaviour as the timer
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			pwm_control_reg_r <= `SVI_RST_BYTE;
		end else begin
			if (wr_hit(wr, i_address, `SVI_ADDR_PWMCTL)) begin
				pwm_control_reg_r <= i_writedata & `SVI_PWM_MASK;
			end
			pwm_control_reg_r[`SVI_CTL_PEND] <= clr_only(pwm_control_reg_r[`SVI_CTL_PEND],
				~wr_hit(wr, i_address, `SVI_ADDR_PWMCTL) | i_writedata[`SVI_CTL_PEND],
				i_pwm_ovf);
		end
	end

	// Pin pending register: two enables, two sticky pendings
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			pin_irq_pending_reg_r <= `SVI_RST_BYTE;
		end else begin
			if (wr_hit(wr, i_address, `SVI_ADDR_PINPND)) begin
				pin_irq_pending_reg_r <= i_writedata & `SVI_PIN_MASK;
			end
			pin_irq_pending_reg_r[`SVI_PIN0_PEND] <= clr_only(
				pin_irq_pending_reg_r[`SVI_PIN0_PEND],
				~wr_hit(wr, i_address, `SVI_ADDR_PINPND) | i_writedata[`SVI_PIN0_PEND],
				pin0_fall);
			pin_irq_pending_reg_r[`SVI_PIN1_PEND] <= clr_only(
				pin_irq_pending_reg_r[`SVI_PIN1_PEND],
				~wr_hit(wr, i_address, `SVI_ADDR_PINPND) | i_writedata[`SVI_PIN1_PEND],
				pin1_fall);
		end
	end

	// Plain data registers passed to the peripherals
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			timer0_match_value_reg_r   <= `SVI_RST_BYTE;
			pwm_duty_reg_r             <= `SVI_RST_BYTE;
			pwm_duty_reg_b_r           <= `SVI_RST_BYTE;
			port_zero_config_low_reg_r <= `SVI_RST_BYTE;
		end else begin
			if (wr_hit(wr, i_address, `SVI_ADDR_T0DATA)) begin
				timer0_match_value_reg_r <= i_writedata;
			end
			if (wr_hit(wr, i_address, `SVI_ADDR_PWM_DUTY_REG)) begin
				pwm_duty_reg_r <= i_writedata;
			end
			if (wr_hit(wr, i_address, `SVI_ADDR_PWMDB)) begin
				pwm_duty_reg_b_r <= i_writedata;
			end
			if (wr_hit(wr, i_address, `SVI_ADDR_P0CFG)) begin
				port_zero_config_low_reg_r <= i_writedata;
			end
		end
	end
	assign o_t0_ctl     = timer0_control_reg_r;
	assign o_pwm_ctl    = pwm_control_reg_r;
	assign o_t0_data    = timer0_match_value_reg_r;
	assign o_pwm_data   = pwm_duty_reg_r;
	assign o_pwm_data_b = pwm_duty_reg_b_r;
	assign o_p0_cfg     = port_zero_config_low_reg_r;
	assign o_pwm_clr    = pwm_control_reg_r[`SVI_CTL_CLR];
	assign o_t0_clr     = timer0_control_reg_r[`SVI_CTL_CLR];

	// The four sources, all equal: no priority, software polls them
	assign src_pend[`SVI_SRC_PWM]  = pwm_control_reg_r[`SVI_CTL_PEND];
	assign src_pend[`SVI_SRC_T0]   = timer0_control_reg_r[`SVI_CTL_PEND];
	assign src_pend[`SVI_SRC_PIN0] = pin_irq_pending_reg_r[`SVI_PIN0_PEND];
	assign src_pend[`SVI_SRC_PIN1] = pin_irq_pending_reg_r[`SVI_PIN1_PEND];
	assign src_en[`SVI_SRC_PWM]    = pwm_control_reg_r[`SVI_CTL_EN];
	assign src_en[`SVI_SRC_T0]     = timer0_control_reg_r[`SVI_CTL_EN];
	assign src_en[`SVI_SRC_PIN0]   = pin_irq_pending_reg_r[`SVI_PIN0_EN];
	assign src_en[`SVI_SRC_PIN1]   = pin_irq_pending_reg_r[`SVI_PIN1_EN];

	// Single request line; which source fired is left to the handler
	assign o_irq_req = (|(src_pend & src_en)) & system_mode_reg_r[`SVI_SYM_GIE];
	// Taken only at an instruction boundary and while idle
	assign take = o_irq_req & i_instr_end & (state_r == SVI_IDLE);

	// Sequencer step order
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SVI_IDLE: begin
				if (take) begin
					state_nxt = SVI_PUSH_PCL;
				end else if (i_return_from_interrupt) begin
					state_nxt = SVI_POP_FLG;
				end
			end
			SVI_PUSH_PCL: if (i_mem_ready) state_nxt = SVI_PUSH_PCH;
			SVI_PUSH_PCH: if (i_mem_ready) state_nxt = SVI_PUSH_FLG;
			SVI_PUSH_FLG: if (i_mem_ready) state_nxt = SVI_FETCH_HI;
			SVI_FETCH_HI: if (i_mem_ready) state_nxt = SVI_FETCH_LO;
			SVI_FETCH_LO: if (i_mem_ready) state_nxt = SVI_BRANCH;
			SVI_BRANCH:   state_nxt = SVI_IDLE;
			// Pops undo the pushes in reverse order
			SVI_POP_FLG:  if (i_mem_ready) state_nxt = SVI_POP_PCH;
			SVI_POP_PCH:  if (i_mem_ready) state_nxt = SVI_POP_PCL;
			SVI_POP_PCL:  if (i_mem_ready) state_nxt = SVI_BRANCH;
			default:      state_nxt = SVI_IDLE;
		endcase
	end

	// Sequencer state
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state_r <= SVI_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Capture fetched and popped bytes
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			vec_hi_r  <= `SVI_RST_BYTE;
			pop_flg_r <= `SVI_RST_BYTE;
			pop_pch_r <= `SVI_RST_BYTE;
		end else if (i_mem_ready) begin
			case (state_r)
				SVI_FETCH_HI: vec_hi_r  <= i_mem_rdata;
				SVI_POP_FLG:  pop_flg_r <= i_mem_rdata;
				SVI_POP_PCH:  pop_pch_r <= i_mem_rdata;
				default:      vec_hi_r  <= vec_hi_r;
			endcase
		end
	end

	// Branch output, registered; last byte lands directly in the pc
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_branch <= '0;
		end else begin
			o_branch.load <= 1'b0;
			if (i_mem_ready & (state_r == SVI_FETCH_LO)) begin
				o_branch.pc     <= {vec_hi_r, i_mem_rdata};
				o_branch.flags  <= `SVI_RST_BYTE;
				o_branch.is_ret <= 1'b0;
				o_branch.load   <= 1'b1;
			end
			if (i_mem_ready & (state_r == SVI_POP_PCL)) begin
				o_branch.pc     <= {pop_pch_r, i_mem_rdata};
				o_branch.flags  <= pop_flg_r;
				o_branch.is_ret <= 1'b1;
				o_branch.load   <= 1'b1;
			end
		end
	end

	// Memory request decode per step; pc and flags are taken live from the core
	always_comb begin
		o_mem = '0;
		case (state_r)
			SVI_PUSH_PCL: begin
				o_mem.push  = 1'b1;
				o_mem.wdata = i_pc[7:0];
			end
			SVI_PUSH_PCH: begin
				o_mem.push  = 1'b1;
				o_mem.wdata = i_pc[15:8];
			end
			SVI_PUSH_FLG: begin
				o_mem.push  = 1'b1;
				o_mem.wdata = i_flags;
			end
			SVI_FETCH_HI: begin
				o_mem.fetch = 1'b1;
				o_mem.addr  = `SVI_VEC_HI_ADDR;
			end
			SVI_FETCH_LO: begin
				o_mem.fetch = 1'b1;
				o_mem.addr  = `SVI_VEC_LO_ADDR;
			end
			SVI_POP_FLG, SVI_POP_PCH, SVI_POP_PCL: o_mem.pop = 1'b1;
			default: o_mem = '0;
		endcase
	end
	assign o_busy = (state_r != SVI_IDLE);

endmodule
`default_nettype wire

//--- bench/svi_checker.sv
// Concurrent checks on the ports of the interrupt unit
`timescale 1ns/1ps
`default_nettype none
`include "svi_regs.svh"
module svi_checker
	import svi_pkg::*;
(
	input wire logic         i_clock,
	input wire logic         i_rst,
	input wire logic         i_read,
	input wire logic         i_write,
	input wire logic [7:0]   i_address,
	input wire logic         i_instr_end,
	input wire logic         i_return_from_interrupt,
	input wire logic [15:0]  i_pc,
	input wire logic [7:0]   i_flags,
	input wire logic         i_mem_ready,
	input wire logic [7:0]   i_mem_rdata,
	input wire logic         o_waitrequest,
	input wire logic         o_irq_req,
	input wire logic         o_busy,
	input wire svi_mem_req_t o_mem,
	input wire svi_branch_t  o_branch,
	input wire logic         o_pwm_clr,
	input wire logic [7:0]   o_t0_ctl
);
	logic [7:0] hi_r;                                      // Handler high byte from vector
	wire logic  take = o_irq_req & i_instr_end & ~o_busy;  // Acknowledge point
	// Keep the high byte so the branch target can be rebuilt later
	always_ff @(posedge i_clock) begin
		if (o_mem.fetch && o_mem.addr == 16'h0000 && i_mem_ready) begin
			hi_r <= i_mem_rdata;
		end
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	AST_TAKE: assert property (take |=> o_busy && o_mem.push && o_mem.wdata == i_pc[7:0])
		else $error("acknowledge did not start with a pc low push");
	AST_GATE: assert property (take |=> !o_irq_req)
		else $error("request still raised after acknowledge");
	AST_PUSH: assert property (o_mem.push && i_mem_ready && o_mem.wdata == i_pc[15:8]
		|=> o_mem.push && o_mem.wdata == i_flags)
		else $error("flags not pushed after pc high");
	AST_VEC_HI: assert property (o_mem.push && i_mem_ready && o_mem.wdata == i_flags
		|=> o_mem.fetch && o_mem.addr == 16'h0000)
		else $error("high vector fetch missing after flags push");
	AST_VEC_LO: assert property (o_mem.fetch && o_mem.addr == 16'h0000 && i_mem_ready
		|=> o_mem.fetch && o_mem.addr == 16'h0001)
		else $error("low vector fetch missing");
	AST_BRANCH: assert property (o_mem.fetch && o_mem.addr == 16'h0001 && i_mem_ready
		|=> o_branch.load && !o_branch.is_ret && o_branch.pc == {hi_r, $past(i_mem_rdata)})
		else $error("branch target wrong");
	AST_RET: assert property (i_return_from_interrupt && !o_busy && !take |=> o_busy && o_mem.pop)
		else $error("return did not start popping");
	AST_RD_LAT: assert property ($rose(i_read) |-> o_waitrequest ##1 !o_waitrequest)
		else $error("read answer timing wrong");
	AST_PEND: assert property (o_t0_ctl[0] && !(i_write && i_address == `SVI_ADDR_T0CTL)
		|=> o_t0_ctl[0])
		else $error("timer pending lost without a write");
	AST_CLR: assert property (o_pwm_clr && !(i_write && i_address == `SVI_ADDR_PWMCTL)
		|=> o_pwm_clr)
		else $error("pwm counter clear bit dropped by itself");
endmodule
`default_nettype wire

//--- bench/svi_core_model.sv
// Core sequencer model: stack memory and program memory holding the vector
`timescale 1ns/1ps
`default_nettype none
module svi_core_model
	import svi_pkg::*;
#(
	parameter logic [7:0] VEC_HI = 8'h4c,  // Arbitrary handler high byte
	parameter logic [7:0] VEC_LO = 8'h21   // Arbitrary handler low byte
)
(
	input  wire logic         i_clock,
	input  wire logic         i_rst,
	input  wire logic         i_slow,    // Answer after extra wait cycles
	input  wire svi_mem_req_t i_mem,
	output logic              o_ready,
	output logic [7:0]        o_rdata
);
	logic [7:0] stk [0:7];  // Stack bytes, grows upward
	logic [2:0] sp;         // Next free stack slot
	logic [1:0] cnt;        // Wait cycles spent in slow mode
	wire logic  req = i_mem.push | i_mem.pop | i_mem.fetch;
	// One ready pulse per step; data toggles when not valid so stale bytes never match
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_ready <= 1'b0;
			sp <= 3'd0;
			cnt <= 2'd0;
			o_rdata <= 8'h00;
		end else if (o_ready) begin
			o_ready <= 1'b0;
			cnt <= 2'd0;
			o_rdata <= ~o_rdata;
			if (i_mem.push) begin
				stk[sp] <= i_mem.wdata;
				sp <= sp + 3'd1;
			end
			if (i_mem.pop) begin
				sp <= sp - 3'd1;
			end
		end else if (req && (!i_slow || cnt == 2'd3)) begin
			o_ready <= 1'b1;
			o_rdata <= i_mem.fetch ? ((i_mem.addr == 16'h0000) ? VEC_HI : VEC_LO)
				: stk[sp - 3'd1];
		end else begin
			cnt <= req ? cnt + 2'd1 : 2'd0;
			o_rdata <= ~o_rdata;
		end
	end
endmodule
`default_nettype wire

//--- bench/tb.sv
// Testbench top: bus tasks, interrupt scenarios and verdict
`timescale 1ns/1ps
`default_nettype none
`include "svi_regs.svh"
module tb import svi_pkg::*;;
	localparam logic [7:0] VH = 8'h4c;  // Arbitrary handler high byte
	localparam logic [7:0] VL = 8'h21;  // Arbitrary handler low byte
	logic         i_clock;
	logic         i_rst = 1'b1;
	logic [7:0]   i_address = 8'h00;
	logic         i_read = 1'b0;
	logic         i_write = 1'b0;
	logic [7:0]   i_writedata = 8'h00;
	logic [15:0]  i_pc = 16'h0000;
	logic [7:0]   i_flags = 8'h00;
	logic [5:0]   ev = 6'h00;   // Pulses: pwm, timer, on, off, return, instr end
	logic [1:0]   pin = 2'b11;  // External lines, idle high
	logic         slow = 1'b0;  // Partner answers slowly
	wire logic [7:0]   o_readdata;
	wire logic         o_waitrequest;
	wire logic         o_irq_req;
	wire logic         o_busy;
	wire logic         o_pwm_clr;
	wire logic         o_t0_clr;
	wire logic         i_mem_ready;
	wire logic [7:0]   i_mem_rdata;
	wire logic [2:0]   o_page;
	wire logic [7:0]   o_t0_ctl, o_pwm_ctl, o_t0_data;      // Register views to peripherals
	wire logic [7:0]   o_pwm_data, o_pwm_data_b, o_p0_cfg;  // Register views to peripherals
	wire svi_mem_req_t o_mem;
	wire svi_branch_t  o_branch;
	svi_branch_t       br;      // Last branch load seen
	int                n_errors = 0;
	int                n_checks = 0;
	int                cyc = 0;
	logic [7:0] adr [9] = '{8'hd1, 8'hd2, 8'hdf, 8'he7, 8'he8, 8'hf0, 8'hf2, 8'hf3, 8'h10};
	logic [7:0] msk [9] = '{8'hff, 8'hca, 8'h0f, 8'hff, 8'h0a, 8'hff, 8'hff, 8'hde, 8'h00};
	svi_unit svi_unit_inst (.i_clock, .i_rst, .i_address, .i_read, .i_write, .i_writedata,
		.o_readdata, .o_waitrequest, .i_pwm_ovf(ev[0]), .i_t0_match(ev[1]), .i_pin0(pin[0]),
		.i_pin1(pin[1]), .i_instr_end(ev[5]), .i_irq_on(ev[2]), .i_irq_off(ev[3]),
		.i_return_from_interrupt(ev[4]), .i_pc, .i_flags, .i_mem_ready, .i_mem_rdata, .o_irq_req, .o_busy,
		.o_mem, .o_branch, .o_pwm_clr, .o_t0_clr, .o_t0_ctl, .o_pwm_ctl, .o_t0_data,
		.o_pwm_data, .o_pwm_data_b, .o_p0_cfg, .o_page);
	svi_core_model #(.VEC_HI(VH), .VEC_LO(VL)) svi_core_model_inst (.i_clock, .i_rst,
		.i_slow(slow), .i_mem(o_mem), .o_ready(i_mem_ready), .o_rdata(i_mem_rdata));
	// 40 MHz clock
	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end
	// Record every branch load the unit hands to the core
	always @(posedge i_clock) begin
		if (o_branch.load === 1'b1) begin
			br <= o_branch;
		end
	end
	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			$display("unexpected %s: expected %h seen %h", n, e, g);
			n_errors++;
		end
	endtask
	// One Avalon transfer; waitrequest and read data taken at the rising edge
	task automatic bus(input logic r, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic w;
		@(posedge i_clock);
		i_address <= a;
		i_read <= r;
		i_write <= !r;
		i_writedata <= d;
		do begin
			@(posedge i_clock);
			w = o_waitrequest;
			q = o_readdata;
		end while (w !== 1'b0);
		i_read <= 1'b0;
		i_write <= 1'b0;
		// Let the write land before callers look at the outputs
		@(negedge i_clock);
	endtask
	task automatic pulse(input int k);
		@(posedge i_clock);
		ev[k] <= 1'b1;
		@(posedge i_clock);
		ev[k] <= 1'b0;
	endtask
	task automatic rq(input logic e);
		@(negedge i_clock);
		chk("request", {15'h0, e}, {15'h0, o_irq_req});
	endtask
	task automatic idle_wait;
		@(posedge i_clock);
		do @(negedge i_clock); while (o_busy === 1'b1);
		repeat (2) @(posedge i_clock);
	endtask
	// Full service: acknowledge, vector branch, pending clear, return
	task automatic service(input logic s, input logic [15:0] pc, input logic [7:0] fl,
		input logic [7:0] pv);
		logic [7:0] q;
		@(posedge i_clock);
		slow <= s;
		i_pc <= pc;
		i_flags <= fl;
		pulse(5);
		idle_wait();
		chk("vector", {VH, VL}, br.pc);
		chk("stack pc", pc, {svi_core_model_inst.stk[1], svi_core_model_inst.stk[0]});
		chk("stack flags", {8'h00, fl}, {8'h00, svi_core_model_inst.stk[2]});
		rq(1'b0);
		bus(1'b1, `SVI_ADDR_PINPND, 8'h00, q);
		chk("pending kept", {8'h00, pv}, {8'h00, q});
		bus(1'b0, `SVI_ADDR_PINPND, pv & 8'hfa, q);
		pulse(4);
		idle_wait();
		chk("return pc", pc, br.pc);
		chk("return flags", {8'h00, fl}, {8'h00, br.flags});
		chk("return kind", 16'h0001, {15'h0, br.is_ret});
		bus(1'b1, `SVI_ADDR_SYSMODE, 8'h00, q);
		chk("gate back", 16'h0008, {8'h00, q});
	endtask
	initial begin
		logic [7:0] q;
		repeat (5) @(posedge i_clock);
		i_rst <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			bus(1'b1, adr[i], 8'h00, q);
			chk("reset value", 16'h0000, {8'h00, q});
			bus(1'b0, adr[i], 8'hff, q);
			bus(1'b1, adr[i], 8'h00, q);
			chk("write mask", {8'h00, msk[i]}, {8'h00, q});
			bus(1'b0, adr[i], 8'h00, q);
		end
		bus(1'b0, `SVI_ADDR_SYSMODE, 8'h07, q);
		chk("page", 16'h0007, {13'h0, o_page});
		bus(1'b0, `SVI_ADDR_T0CTL, 8'h08, q);
		bus(1'b0, `SVI_ADDR_PWMCTL, 8'h08, q);
		chk("counter clears", 16'h0003, {14'h0, o_pwm_clr, o_t0_clr});
		chk("control ports", 16'h0808, {o_t0_ctl, o_pwm_ctl});
		bus(1'b0, `SVI_ADDR_T0CTL, 8'h00, q);
		bus(1'b0, `SVI_ADDR_PWMCTL, 8'h00, q);
		bus(1'b0, `SVI_ADDR_T0DATA, 8'h5a, q);
		bus(1'b0, `SVI_ADDR_PWM_DUTY_REG, 8'ha5, q);
		bus(1'b0, `SVI_ADDR_PWMDB, 8'h3c, q);
		bus(1'b0, `SVI_ADDR_P0CFG, 8'hc3, q);
		chk("data ports", 16'h5aa5, {o_t0_data, o_pwm_data});
		chk("data ports b", 16'h3cc3, {o_pwm_data_b, o_p0_cfg});
		$display("test registers done");
		bus(1'b0, `SVI_ADDR_SYSMODE, 8'h00, q);
		bus(1'b0, `SVI_ADDR_T0CTL, 8'h02, q);
		pulse(1);
		rq(1'b0);
		pulse(2);
		rq(1'b1);
		pulse(3);
		rq(1'b0);
		pulse(2);
		bus(1'b0, `SVI_ADDR_T0CTL, 8'h03, q);
		bus(1'b1, `SVI_ADDR_T0CTL, 8'h00, q);
		chk("timer pending", 16'h0003, {8'h00, q});
		bus(1'b0, `SVI_ADDR_T0CTL, 8'h01, q);
		rq(1'b0);
		bus(1'b0, `SVI_ADDR_T0CTL, 8'h00, q);
		bus(1'b0, `SVI_ADDR_PWMCTL, 8'h02, q);
		pulse(0);
		rq(1'b1);
		bus(1'b0, `SVI_ADDR_PWMCTL, 8'h02, q);
		rq(1'b0);
		$display("test gating done");
		for (int k = 0; k < 2; k++) begin
			bus(1'b0, `SVI_ADDR_PINPND, (k == 1) ? 8'h08 : 8'h02, q);
			@(posedge i_clock);
			pin <= (k == 1) ? 2'b01 : 2'b10;
			repeat (6) @(posedge i_clock);
			pin <= 2'b11;
			rq(1'b1);
			service(k == 1, (k == 1) ? 16'h2468 : 16'h1234, (k == 1) ? 8'h9c : 8'h5a,
				(k == 1) ? 8'h0c : 8'h03);
			$display("test pin line %0d done", k);
		end
		summarize();
	end
endmodule
bind svi_unit svi_checker svi_checker_inst (.i_clock, .i_rst, .i_read, .i_write, .i_address,
	.i_instr_end, .i_return_from_interrupt, .i_pc, .i_flags, .i_mem_ready, .i_mem_rdata, .o_waitrequest,
	.o_irq_req, .o_busy, .o_mem, .o_branch, .o_pwm_clr, .o_t0_ctl);
`default_nettype wire
